// ### rtl/usi_pkg.sv
// Purpose: shared constants and types of the bus event status interrupt block
// Assumes: 25 MHz hclk, registers reached over AHB-Lite, one word per register
// Notes: second level error flags live outside; flags and enables both enter here, gated and ORed
package usi_pkg;

   // register byte offsets
   localparam logic [7:0] OFF_FLAGS = 8'h00;
   localparam logic [7:0] OFF_ENABLES = 8'h04;
   localparam logic [7:0] OFF_CONTROL = 8'h08;
   localparam logic [7:0] OFF_ADDRESS = 8'h0C;
   localparam logic [7:0] OFF_UNMAPPED = 8'hFF;

   // bit positions in bus_event_flags and bus_event_enables
   localparam int BIT_SOF = 6;
   localparam int BIT_HALT = 5;
   localparam int BIT_IDLE = 4;
   localparam int BIT_TRN = 3;
   localparam int BIT_ACT = 2;
   localparam int BIT_ERR = 1;
   localparam int BIT_RST = 0;

   // bit position of suspend_control_bit in module_control_register
   localparam int BIT_SUSPEND = 1;

   // values after reset
   localparam logic [6:0] FLAGS_RESET = 7'h00;
   localparam logic [6:0] ENABLES_RESET = 7'h00;
   localparam logic [6:0] ADDRESS_RESET = 7'h00;
   localparam logic SUSPEND_RESET = 1'b0;

   // flag bits firmware may write; the error summary is status only
   localparam logic [6:0] FLAGS_SW_MASK = 7'h7D;

   // AHB encodings used by the slave
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // timing: bus idle time and the resync delay after wake-up
   localparam int CLK_KHZ = 25000;
   localparam int IDLE_TIME_US = 3000;
   localparam int IDLE_CYCLES = (IDLE_TIME_US * CLK_KHZ + 999) / 1000;
   localparam int RESYNC_CYCLES = 4;

   // arming of the wake activity flag between idle periods
   typedef enum logic {
      WAKE_DISARMED = 1'b0,
      WAKE_ARMED = 1'b1
   } usi_wake_t;

endpackage

// ### rtl/usi_status_irq.sv
// Purpose: bus event flags, their enables and the single module interrupt request
// Assumes: engine events are one-cycle pulses on hclk; pins are asynchronous levels
// Notes: zero wait state AHB-Lite slave, always OKAY; unmapped words read zero
//
// Notes on behaviour
// R1: interrupt request is the OR of every flag ANDed with its enable
// R2: hardware-set flags other than the error summary stay set until firmware writes zero there
// R3: firmware writing one sets any writable flag, raising the same interrupt
// R4: while suspended the engine is unclocked; only activity may set a flag; the error summary bit 1 still follows enabled errors
// R5: bit 7 of flags and enables reads zero and ignores writes
// R6: start-of-frame token received sets flag bit 6
// R7: stall handshake sent sets flag bit 5
// R8: bus idle for 3 ms or more sets flag bit 4
// R9: finished transaction sets flag bit 3; transfer status then readable
// R10: clearing transfer done advances the status FIFO, token entries only
// R11: activity on the data lines sets flag bit 2
// R12: error summary bit 1 is read only, set by enabled errors alone
// R13: valid bus reset sets flag bit 0 and zeroes the device address
// R14: clears of the activity flag ignored while suspended or just after wake
// R15: firmware leaves suspend then clears activity repeatedly until it reads zero
// R16: activity flag raised once per resume; rearmed only by a new idle
// R17: with the PLL clock, module stays non-operational until lock
// R18: enable bits 6..0 gate their flags; all enables reset to zero
// R19: flags set regardless of enables; enables only gate the request
// R20: firmware should unmask activity only after idle, then may suspend
// R21: error summary is the OR of error flags gated by error enables
// R22: one module interrupt request feeds the CPU peripheral flag bit
// R23: a hardware set in the same cycle as a firmware clear wins
`timescale 1ns/10ps
`default_nettype none
module usi_status_irq
   import usi_pkg::*;
#(
   parameter int IDLE_LIMIT = IDLE_CYCLES,
   parameter int ERR_WIDTH = 8
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // serial engine events, one-cycle pulses on hclk
   input wire logic sof_event,
   input wire logic halt_event,
   input wire logic trn_event,
   input wire logic bus_reset_event,
   input wire logic trn_entry_is_token,
   // second level error flags and their enables
   input wire logic [ERR_WIDTH-1:0] error_flag_vec,
   input wire logic [ERR_WIDTH-1:0] error_enable_vec,
   // asynchronous pin levels
   input wire logic bus_idle_pin,
   input wire logic dline_activity_pin,
   input wire logic pll_lock_pin,
   // outputs toward engine, FIFO and CPU
   output logic module_interrupt_request,
   output logic serial_engine_clock_enable,
   output logic module_operational,
   output logic fifo_advance,
   output logic [6:0] device_address
);
   typedef struct packed {
      logic sel;
      logic wr;
      logic [7:0] addr;
      logic [31:0] rdata;
      logic ready;
      logic [6:0] flags;
      logic [6:0] en;
      logic suspend;
      logic [6:0] dev_addr;
      usi_wake_t wake;
      logic irq;
      logic adv;
      logic sclk_en;
      logic oper;
   } usi_state_t;

   usi_state_t s_q;
   usi_state_t s_d;

   logic idle_sync;
   logic act_sync;
   logic lock_sync;
   logic idle_hit;
   logic resync_full;

   // pin levels cross into hclk before anything looks at them
   usi_sync #(
      .WIDTH(3)
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .async_in({bus_idle_pin, dline_activity_pin, pll_lock_pin}),
      .sync_out({idle_sync, act_sync, lock_sync})
   );

   // unbroken idle on the bus for the full idle time
   usi_timer #(
      .LIMIT(IDLE_LIMIT)
   ) u_idle (
      .hclk(hclk),
      .hresetn(hresetn),
      .run(idle_sync),
      .hit(idle_hit),
      .full()
   );

   // a few cycles awake and locked before activity clears are honoured
   usi_timer #(
      .LIMIT(RESYNC_CYCLES)
   ) u_resync (
      .hclk(hclk),
      .hresetn(hresetn),
      .run(s_q.oper),
      .hit(),
      .full(resync_full)
   );

   logic [6:0] hw_set;
   logic [6:0] nw;
   logic live;
   logic act_clear_ok;
   logic err_sum;
   logic wr_flags;

   // engine events only count while it is clocked and the PLL is locked
   always_comb begin
      // suspend gates at once; the registered operational flag lags it a cycle
      live = s_q.oper && !s_q.suspend; // R4 R17
      err_sum = |(error_flag_vec & error_enable_vec); // R21
      act_clear_ok = !s_q.suspend && resync_full; // R14
      wr_flags = s_q.sel && s_q.wr && (s_q.addr == OFF_FLAGS);
      hw_set = '0;
      hw_set[BIT_SOF] = live && sof_event; // R6
      hw_set[BIT_HALT] = live && halt_event; // R7
      hw_set[BIT_IDLE] = live && idle_hit; // R8
      hw_set[BIT_TRN] = live && trn_event; // R9
      hw_set[BIT_ACT] = (s_q.wake == WAKE_ARMED) && act_sync; // R11 R16
      hw_set[BIT_RST] = live && bus_reset_event; // R13
   end

   // next state: data phase writes first, then hardware sets on top
   always_comb begin
      s_d = s_q;
      s_d.adv = 1'b0;
      s_d.ready = 1'b1;
      nw = s_q.flags;
      if (s_q.sel && s_q.wr) begin
         unique case (s_q.addr)
            OFF_FLAGS: begin
               // writable bits take the written value, both ones and zeros
               nw = (s_q.flags & ~FLAGS_SW_MASK) | (hwdata[6:0] & FLAGS_SW_MASK); // R2 R3
               if (!act_clear_ok) begin
                  nw[BIT_ACT] = s_q.flags[BIT_ACT] | hwdata[BIT_ACT]; // R14 R15
               end
               // a set in the same cycle keeps the entry in place
               s_d.adv = s_q.flags[BIT_TRN] && !hwdata[BIT_TRN] && !hw_set[BIT_TRN]
                  && trn_entry_is_token; // R10 R23
               s_d.flags = nw;
            end
            OFF_ENABLES: begin
               s_d.en = hwdata[6:0]; // R5 R18
            end
            OFF_CONTROL: begin
               s_d.suspend = hwdata[BIT_SUSPEND]; // R4
            end
            OFF_ADDRESS: begin
               s_d.dev_addr = hwdata[6:0];
            end
            default: begin
            end
         endcase
      end
      // hardware sets override any clear written in the same cycle
      s_d.flags = s_d.flags | hw_set; // R19 R23
      s_d.flags[BIT_ERR] = err_sum; // R12
      if (hw_set[BIT_RST]) begin
         s_d.dev_addr = ADDRESS_RESET; // R13
      end
      // one activity flag per resume; idle time rearms it
      if (hw_set[BIT_ACT]) begin
         s_d.wake = WAKE_DISARMED; // R16
      end else if (hw_set[BIT_IDLE]) begin
         s_d.wake = WAKE_ARMED; // R16
      end
      s_d.irq = |(s_q.flags & s_q.en); // R1 R18 R22
      s_d.sclk_en = !s_q.suspend; // R4
      s_d.oper = !s_q.suspend && lock_sync; // R17
      // address phase capture; upper address bits outside the map
      s_d.sel = hsel && hready && htrans[1];
      s_d.wr = hwrite && (hsize == HSIZE_WORD);
      s_d.addr = (haddr[31:8] == 24'h000000) ? haddr[7:0] : OFF_UNMAPPED;
      // read data from next-state values so a write just before is seen
      s_d.rdata = 32'h00000000;
      if (s_d.sel && !hwrite) begin
         unique case (s_d.addr)
            OFF_FLAGS: s_d.rdata = {25'h0000000, s_d.flags}; // R5
            OFF_ENABLES: s_d.rdata = {25'h0000000, s_d.en}; // R5
            OFF_CONTROL: s_d.rdata = {30'h00000000, s_d.suspend, 1'b0};
            OFF_ADDRESS: s_d.rdata = {25'h0000000, s_d.dev_addr};
            default: s_d.rdata = 32'h00000000;
         endcase
      end
   end

   // every control bit has a defined value from reset onward
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q.sel <= 1'b0;
         s_q.wr <= 1'b0;
         s_q.addr <= OFF_UNMAPPED;
         s_q.rdata <= 32'h00000000;
         s_q.ready <= 1'b1;
         s_q.flags <= FLAGS_RESET;
         s_q.en <= ENABLES_RESET; // R18
         s_q.suspend <= SUSPEND_RESET;
         s_q.dev_addr <= ADDRESS_RESET;
         s_q.wake <= WAKE_DISARMED;
         s_q.irq <= 1'b0;
         s_q.adv <= 1'b0;
         s_q.sclk_en <= 1'b0;
         s_q.oper <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register; hresp tied to zero
   assign hrdata = s_q.rdata;
   assign hreadyout = s_q.ready;
   assign hresp = 1'b0;
   assign module_interrupt_request = s_q.irq;
   assign serial_engine_clock_enable = s_q.sclk_en;
   assign module_operational = s_q.oper;
   assign fifo_advance = s_q.adv;
   assign device_address = s_q.dev_addr;

   // checks on the flag and request logic
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   irq_raise_a: assert property ( // R1
      |(s_q.flags & s_q.en) |=> s_q.irq)
      else $error("enabled flag did not raise request");

   irq_quiet_a: assert property ( // R18
      !(|(s_q.flags & s_q.en)) |=> !s_q.irq)
      else $error("request raised with no enabled flag");

   flag_hold_a: assert property ( // R2
      s_q.flags[BIT_HALT] && !wr_flags |=> s_q.flags[BIT_HALT])
      else $error("halt flag dropped without a write");

   sw_set_a: assert property ( // R3
      wr_flags && hwdata[BIT_SOF] |=> s_q.flags[BIT_SOF] ##1 s_q.irq || !s_q.en[BIT_SOF])
      else $error("software set of frame start flag failed");

   suspend_gate_a: assert property ( // R4
      s_q.suspend && !wr_flags && !s_q.flags[BIT_TRN] |=> !s_q.flags[BIT_TRN])
      else $error("transfer flag set while suspended");

   bit7_zero_a: assert property ( // R5
      s_q.rdata[31:7] == 25'h0000000)
      else $error("upper read bits not zero");

   poll_set_a: assert property ( // R19
      live && halt_event && !s_q.en[BIT_HALT] && !(|(s_q.flags & s_q.en))
      |=> s_q.flags[BIT_HALT] && !s_q.irq)
      else $error("disabled halt event not flagged");

   set_wins_a: assert property ( // R23
      live && trn_event && wr_flags && !hwdata[BIT_TRN] |=> s_q.flags[BIT_TRN] && !s_q.adv)
      else $error("clear beat a hardware set");

   fifo_adv_a: assert property ( // R10
      wr_flags && s_q.flags[BIT_TRN] && !hwdata[BIT_TRN] && !(live && trn_event)
      && trn_entry_is_token |=> s_q.adv && !s_q.flags[BIT_TRN] ##1 !s_q.adv)
      else $error("transfer clear did not advance once");

   bus_rst_a: assert property ( // R13
      live && bus_reset_event |=> s_q.flags[BIT_RST] && s_q.dev_addr == ADDRESS_RESET)
      else $error("bus reset not applied");

   act_once_a: assert property ( // R16
      s_q.wake == WAKE_DISARMED && !wr_flags && !s_q.flags[BIT_ACT] |=> !s_q.flags[BIT_ACT])
      else $error("activity flag set without rearm");

   err_sum_a: assert property ( // R12
      |(error_flag_vec & error_enable_vec) |=> s_q.flags[BIT_ERR])
      else $error("error summary missed");

   act_keep_a: assert property ( // R14
      s_q.suspend && s_q.flags[BIT_ACT] && wr_flags |=> s_q.flags[BIT_ACT])
      else $error("activity cleared while suspended");

   // checks on the frame, halt and transfer events, the pins and the wake-up timing
   sof_set_a: assert property ( // R6
      live && sof_event |=> s_q.flags[BIT_SOF])
      else $error("frame start event not flagged");

   halt_set_a: assert property ( // R7
      live && halt_event |=> s_q.flags[BIT_HALT])
      else $error("halt event not flagged");

   idle_set_a: assert property ( // R8
      live && idle_hit |=> s_q.flags[BIT_IDLE])
      else $error("idle time not flagged");

   trn_set_a: assert property ( // R9
      live && trn_event |=> s_q.flags[BIT_TRN])
      else $error("transfer done not flagged");

   act_set_a: assert property ( // R11
      s_q.wake == WAKE_ARMED && act_sync |=> s_q.flags[BIT_ACT])
      else $error("armed activity not flagged");

   lock_gate_a: assert property ( // R17
      !lock_sync |=> !s_q.oper)
      else $error("operational without lock");

   suspend_clk_a: assert property ( // R4
      s_q.suspend |=> !s_q.sclk_en && !s_q.oper)
      else $error("engine clocked while suspended");

   resync_wait_a: assert property ( // R14
      !resync_full && s_q.flags[BIT_ACT] && wr_flags |=> s_q.flags[BIT_ACT])
      else $error("activity cleared before resync");

   // main scenarios
   fifo_adv_c: cover property (s_q.adv);
   act_set_c: cover property (s_q.wake == WAKE_ARMED ##1 s_q.flags[BIT_ACT]);
   irq_rise_c: cover property (!s_q.irq ##1 s_q.irq);
   idle_set_c: cover property (hw_set[BIT_IDLE]);
   set_wins_c: cover property (live && trn_event && wr_flags && !hwdata[BIT_TRN]);
endmodule
`default_nettype wire

// ### rtl/usi_sync.sv
// Purpose: two flip-flop synchroniser for pin level inputs
// Assumes: inputs are slow levels; no pulse shorter than two clocks matters
// Notes: only the second stage is visible outside
`timescale 1ns/10ps
`default_nettype none
module usi_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } usi_sync_state_t;

   usi_sync_state_t s_q;
   usi_sync_state_t s_d;

   // the first stage feeds the second stage and nothing else
   always_comb begin
      s_d.meta = async_in;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_out = s_q.stable;
endmodule
`default_nettype wire

// ### rtl/usi_timer.sv
// Purpose: counts cycles while a level stays high and marks when LIMIT is reached
// Assumes: LIMIT is at least one
// Notes: hit is a single cycle pulse; full stays high until run drops
`timescale 1ns/10ps
`default_nettype none
module usi_timer #(
   parameter int LIMIT = 4
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // level to time and results
   input wire logic run,
   output logic hit,
   output logic full
);
   localparam int CW = $clog2(LIMIT + 1);

   typedef struct packed {
      logic [CW-1:0] count;
      logic hit;
      logic full;
   } usi_timer_state_t;

   usi_timer_state_t s_q;
   usi_timer_state_t s_d;

   // any drop of run restarts the whole period, so only unbroken spans count
   always_comb begin
      s_d = s_q;
      s_d.hit = 1'b0;
      if (!run) begin
         s_d.count = '0;
         s_d.full = 1'b0;
      end else if (!s_q.full) begin
         if (s_q.count == CW'(LIMIT - 1)) begin
            s_d.count = CW'(LIMIT);
            s_d.full = 1'b1;
            s_d.hit = 1'b1;
         end else begin
            s_d.count = s_q.count + 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign hit = s_q.hit;
   assign full = s_q.full;
endmodule
`default_nettype wire

// ### testbench/usb_status_interrupt_logic_bench.sv
// Purpose: self-checking bench of the bus event flags and interrupt request
// Assumes: zero wait state slave; idle limit shortened to LIM cycles
// Notes: random enables and flag patterns come from a fixed xorshift seed
`timescale 1ns/10ps
`default_nettype none
module usb_status_interrupt_logic_bench;
   import usi_pkg::*;
   localparam int LIM = 20;
   localparam int EVB [4] = '{BIT_SOF, BIT_HALT, BIT_TRN, BIT_RST};
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd, seed, e, f;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] ev_req;
   logic idle_req, act_req, sof_event, halt_event, trn_event, bus_reset_event;
   logic trn_entry_is_token, bus_idle_pin, dline_activity_pin, pll_lock_pin;
   logic [7:0] error_flag_vec, error_enable_vec;
   logic module_interrupt_request, serial_engine_clock_enable, module_operational;
   logic fifo_advance;
   logic [6:0] device_address;
   int err_count = 0;
   int check_count = 0;
   int cyc = 0;
   int adv_cnt = 0;
   int n;

   usi_status_irq #(.IDLE_LIMIT(LIM), .ERR_WIDTH(8)) dut_u (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .sof_event,
      .halt_event, .trn_event, .bus_reset_event, .trn_entry_is_token, .error_flag_vec,
      .error_enable_vec, .bus_idle_pin, .dline_activity_pin, .pll_lock_pin,
      .module_interrupt_request, .serial_engine_clock_enable, .module_operational,
      .fifo_advance, .device_address);
   usi_engine_model eng_u (.hclk, .hresetn, .ev_req, .idle_req, .act_req, .sof_event,
      .halt_event, .trn_event, .bus_reset_event, .bus_idle_pin, .dline_activity_pin);

   always #20 hclk = ~hclk;

   // cycle ceiling cuts a hang; advance pulses are counted as they stand
   always @(posedge hclk) begin
      cyc++;
      if (fifo_advance === 1'b1) adv_cnt++;
      if (cyc == 20000) begin
         err_count++;
         close_out();
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one single word transfer; read data taken at the data phase edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      hsize <= HSIZE_WORD;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(nm, exp, rd);
   endtask

   task automatic ev(input int i);
      @(posedge hclk);
      ev_req <= 4'h1 << i;
      @(posedge hclk);
      ev_req <= 4'h0;
      repeat (2) @(posedge hclk);
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      {hclk, hresetn, hsel, hwrite, idle_req, act_req} = 6'h00;
      {hready, trn_entry_is_token, pll_lock_pin} = 3'h7;
      {haddr, hwdata} = 64'h0;
      {htrans, hsize, ev_req} = 9'h000;
      {error_flag_vec, error_enable_vec} = 16'h0000;
      seed = 32'h0000_C074;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values, then the unimplemented top bit
      rdchk("flags", OFF_FLAGS, 32'h0);
      rdchk("enables", OFF_ENABLES, 32'h0);
      bus(1'b1, OFF_ENABLES, 32'hFFFF_FFFF);
      rdchk("enables", OFF_ENABLES, 32'h7F);
      bus(1'b1, OFF_ENABLES, 32'h0);
      bus(1'b1, OFF_UNMAPPED, 32'hFFFF_FFFF);
      rdchk("unmapped", OFF_UNMAPPED, 32'h0);
      bus(1'b1, OFF_ADDRESS, 32'h55);
      rdchk("address", OFF_ADDRESS, 32'h55);
      $display("test registers done");
      // each engine event with all enables off: polled, no request
      for (int i = 0; i < 4; i++) begin
         ev(i);
         rdchk("event flag", OFF_FLAGS, 32'h1 << EVB[i]);
         chk("request", 32'h0, {31'h0, module_interrupt_request});
         n = adv_cnt;
         bus(1'b1, OFF_FLAGS, 32'h0);
         rdchk("cleared", OFF_FLAGS, 32'h0);
         chk("advance", n + (i == 2), adv_cnt);
      end
      chk("address", 32'h0, {25'h0, device_address});
      // a transfer event in the clearing write's data phase keeps the flag
      ev(2);
      n = adv_cnt;
      fork
         bus(1'b1, OFF_FLAGS, 32'h0);
         begin
            @(posedge hclk);
            ev_req <= 4'h4;
            @(posedge hclk);
            ev_req <= 4'h0;
         end
      join
      rdchk("set wins", OFF_FLAGS, 32'h08);
      chk("no advance", n, adv_cnt);
      bus(1'b1, OFF_FLAGS, 32'h0);
      repeat (2) @(posedge hclk);
      chk("advance", n + 1, adv_cnt);
      // lock lost: engine events ignored until the PLL relocks
      pll_lock_pin <= 1'b0;
      repeat (4) @(posedge hclk);
      chk("operational", 32'h0, {31'h0, module_operational});
      ev(1);
      rdchk("unlocked", OFF_FLAGS, 32'h0);
      pll_lock_pin <= 1'b1;
      repeat (8) @(posedge hclk);
      chk("operational", 32'h1, {31'h0, module_operational});
      $display("test events done");
      // random enables and firmware-set flags
      for (int k = 0; k < 24; k++) begin
         seed = xs(seed);
         e = seed;
         seed = xs(seed);
         f = (k == 0) ? 32'hFF : seed;
         bus(1'b1, OFF_ENABLES, e);
         bus(1'b1, OFF_FLAGS, f);
         rdchk("sw flags", OFF_FLAGS, f & 32'h7D);
         chk("request", {31'h0, |(f[6:0] & e[6:0] & 7'h7D)}, {31'h0, module_interrupt_request});
      end
      bus(1'b1, OFF_FLAGS, 32'h0);
      bus(1'b1, OFF_ENABLES, 32'h02);
      $display("test random done");
      // error summary follows gated second level errors only
      @(posedge hclk);
      error_flag_vec <= 8'h81;
      error_enable_vec <= 8'h01;
      repeat (3) @(posedge hclk);
      rdchk("error", OFF_FLAGS, 32'h02);
      chk("request", 32'h1, {31'h0, module_interrupt_request});
      bus(1'b1, OFF_FLAGS, 32'h0);
      rdchk("error", OFF_FLAGS, 32'h02);
      error_enable_vec <= 8'h7E;
      repeat (3) @(posedge hclk);
      rdchk("error", OFF_FLAGS, 32'h0);
      bus(1'b1, OFF_ENABLES, 32'h0);
      $display("test errors done");
      // idle timing, then one activity flag per resume
      idle_req <= 1'b1;
      repeat (LIM / 2) @(posedge hclk);
      rdchk("early idle", OFF_FLAGS, 32'h0);
      repeat (LIM) @(posedge hclk);
      rdchk("idle", OFF_FLAGS, 32'h10);
      idle_req <= 1'b0;
      act_req <= 1'b1;
      repeat (4) @(posedge hclk);
      rdchk("activity", OFF_FLAGS, 32'h14);
      bus(1'b1, OFF_FLAGS, 32'h0);
      repeat (4) @(posedge hclk);
      rdchk("no rearm", OFF_FLAGS, 32'h0);
      $display("test idle done");
      // suspend: engine unclocked, only activity sets, clears ignored
      act_req <= 1'b0;
      idle_req <= 1'b1;
      repeat (LIM + 8) @(posedge hclk);
      idle_req <= 1'b0;
      bus(1'b1, OFF_ENABLES, 32'h1 << BIT_ACT);
      bus(1'b1, OFF_FLAGS, 32'h0);
      bus(1'b1, OFF_CONTROL, 32'h1 << BIT_SUSPEND);
      repeat (2) @(posedge hclk);
      chk("engine clock", 32'h0, {31'h0, serial_engine_clock_enable});
      ev(0);
      act_req <= 1'b1;
      repeat (4) @(posedge hclk);
      rdchk("suspended", OFF_FLAGS, 32'h04);
      chk("request", 32'h1, {31'h0, module_interrupt_request});
      bus(1'b1, OFF_FLAGS, 32'h0);
      rdchk("clear ignored", OFF_FLAGS, 32'h04);
      bus(1'b1, OFF_CONTROL, 32'h0);
      act_req <= 1'b0;
      rdchk("pre resume", OFF_FLAGS, 32'h04);
      // firmware resume loop: clear until it reads zero
      for (int k = 0; k < 20 && rd[BIT_ACT] === 1'b1; k++) begin
         bus(1'b1, OFF_FLAGS, 32'h0);
         bus(1'b0, OFF_FLAGS, 32'h0);
      end
      chk("resumed", 32'h0, rd);
      chk("request", 32'h0, {31'h0, module_interrupt_request});
      $display("test suspend done");
      close_out();
   end
endmodule
`default_nettype wire

// ### testbench/usi_engine_model.sv
// Purpose: stand-in for the serial engine and the bus line pins
// Assumes: the bench raises requests just after a rising hclk edge
// Notes: events leave as one-cycle registered pulses, as the engine gives them
`timescale 1ns/10ps
`default_nettype none
module usi_engine_model (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // requests from the bench: 0 frame, 1 halt, 2 transfer, 3 bus reset
   input wire logic [3:0] ev_req,
   input wire logic idle_req,
   input wire logic act_req,
   // toward the block
   output logic sof_event,
   output logic halt_event,
   output logic trn_event,
   output logic bus_reset_event,
   output logic bus_idle_pin,
   output logic dline_activity_pin
);
   // registered so a pulse is exactly one hclk long
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {bus_reset_event, trn_event, halt_event, sof_event} <= 4'h0;
      end else begin
         {bus_reset_event, trn_event, halt_event, sof_event} <= ev_req;
      end
   end
   // pins are raw levels; the block must synchronise them itself
   assign bus_idle_pin = idle_req;
   assign dline_activity_pin = act_req;
endmodule
`default_nettype wire
